// [hdl/sep_defines.vh]
// Constants for the serial EEPROM front end
`ifndef SEP_DEFINES_VH
`define SEP_DEFINES_VH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define SEP_OP_ENABLE_WRITES  8'h06
`define SEP_OP_DISABLE_WRITES 8'h04
`define SEP_OP_STATUS_READ    8'h05
`define SEP_OP_STATUS_WRITE   8'h01
`define SEP_OP_ARRAY_READ     8'h03
`define SEP_OP_ARRAY_WRITE    8'h02
`define SEP_OP_IDPAGE_READ    8'h83
`define SEP_OP_IDPAGE_WRITE   8'h82

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define SEP_LOCK_SEL_BIT      7
`define SEP_QUARTER_BASE      10'h300
`define SEP_HALF_BASE         10'h200

// ----------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------
`define SEP_SR_DISABLE_BIT    7
`define SEP_SR_BP_HI_BIT      3
`define SEP_SR_BP_LO_BIT      2
`define SEP_SR_WEL_BIT        1
`define SEP_SR_BUSY_BIT       0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SEP_CLK_MHZ           125
`define SEP_TW_US             4000

`endif

// [hdl/sep_eeprom.v]
// Serial EEPROM slave: pin protocol, pause, status register and write protection
`default_nettype none
`include "sep_defines.vh"

module sep_eeprom #(
  parameter integer TW_CYCLES = `SEP_TW_US * `SEP_CLK_MHZ,
  parameter integer CNT_W     = 20
) (
  input  wire clk,
  input  wire rst,
  input  wire sclk,
  input  wire cs_n,
  input  wire mosi,
  input  wire hold_n,
  input  wire wp_n,
  output reg  miso,
  output reg  miso_oe
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CMD  = 3'd1;
  localparam [2:0] ST_ADDR = 3'd2;
  localparam [2:0] ST_DATA = 3'd3;
  localparam [2:0] ST_READ = 3'd4;
  localparam [2:0] ST_DONE = 3'd5;
  localparam [2:0] ST_WAIT = 3'd6;

  // ----------------------------------------------------------------
  // Protection decode
  // ----------------------------------------------------------------
  function prot;
    input [9:0] a;
    input [1:0] bp;
    begin
      case (bp)
        2'b01:   prot = (a >= `SEP_QUARTER_BASE);
        2'b10:   prot = (a >= `SEP_HALF_BASE);
        2'b11:   prot = 1'b1;
        default: prot = 1'b0;
      endcase
    end
  endfunction

  function is_page_wr;
    input [7:0] op;
    begin
      is_page_wr = (op == `SEP_OP_ARRAY_WRITE) || (op == `SEP_OP_IDPAGE_WRITE);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [4:0]        s1_q;
  reg [4:0]        s2_q;
  reg              sclk_p_q;
  reg              cs_p_q;
  wire             sclk_s = s2_q[0];
  wire             cs_s   = s2_q[1];
  wire             mosi_s = s2_q[2];
  wire             hold_s = s2_q[3];
  wire             wp_s   = s2_q[4];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2:0]        st_q;
  reg              sel_q;
  reg              paused_q;
  reg [2:0]        bit_q;
  reg [7:0]        sh_q;
  reg [7:0]        op_q;
  reg              lk_q;
  reg              ab_q;
  reg [7:0]        ahi_q;
  reg [9:0]        addr_q;
  reg [4:0]        col_q;
  reg [31:0]       mask_q;
  reg              got_q;
  reg [7:0]        srn_q;
  reg [7:0]        rd_q;
  reg              ld_q;
  reg              drv_q;
  reg              wel_q;
  reg              busy_q;
  reg              status_write_disable_q;
  reg [1:0]        bp_q;
  reg              idlock_q;
  reg [CNT_W-1:0]  cnt_q;
  reg              go_q;
  reg [7:0]        mem   [0:1023];
  reg [7:0]        idp   [0:31];
  reg [7:0]        pbuf  [0:31];
  integer          i;

  // ----------------------------------------------------------------
  // Write cycle snapshot; later commands reuse op and address
  // ----------------------------------------------------------------
  reg [7:0]        wop_q;
  reg [4:0]        wpg_q;
  reg              wlk_q;

  wire             sc_rise   = sclk_s & ~sclk_p_q;
  wire             sc_fall   = ~sclk_s & sclk_p_q;
  wire             cs_fall   = ~cs_s & cs_p_q;
  wire             cs_rise   = cs_s & ~cs_p_q;
  wire             act       = sel_q & ~paused_q & ~cs_s;
  wire             rx        = act & sc_rise;
  wire             tx        = act & sc_fall;
  wire [7:0]       rx_byte   = {sh_q[6:0], mosi_s};
  wire             byte_done = rx & (bit_q == 3'd7);
  wire             bound     = (bit_q == 3'd0);
  wire             sr_locked = status_write_disable_q & ~wp_s;
  wire [15:0]      afull     = {ahi_q, rx_byte};
  wire [7:0]       status    = {status_write_disable_q, 3'h0, bp_q, wel_q, busy_q};
  wire [7:0]       rd_next   = (op_q == `SEP_OP_STATUS_READ) ? status :
                               lk_q ? {7'h0, idlock_q} :
                               (op_q == `SEP_OP_IDPAGE_READ) ? idp[addr_q[4:0]] :
                               mem[addr_q];
  wire             cmd_ok    = ~busy_q | (rx_byte == `SEP_OP_STATUS_READ) |
                               (rx_byte == `SEP_OP_DISABLE_WRITES);

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // Pause and protect wake idle; select wakes low so no false edge
      s1_q     <= 5'h18;
      s2_q     <= 5'h18;
      sclk_p_q <= 1'b0;
      cs_p_q   <= 1'b0;
      st_q     <= ST_IDLE;
      sel_q    <= 1'b0;
      paused_q <= 1'b0;
      bit_q    <= 3'h0;
      sh_q     <= 8'h00;
      op_q     <= 8'h00;
      lk_q     <= 1'b0;
      ab_q     <= 1'b0;
      ahi_q    <= 8'h00;
      addr_q   <= 10'h000;
      col_q    <= 5'h00;
      mask_q   <= 32'h0;
      got_q    <= 1'b0;
      srn_q    <= 8'h00;
      rd_q     <= 8'h00;
      ld_q     <= 1'b0;
      drv_q    <= 1'b0;
      wel_q    <= 1'b0;
      busy_q   <= 1'b0;
      status_write_disable_q   <= 1'b0;
      bp_q     <= 2'h0;
      idlock_q <= 1'b0;
      cnt_q    <= {CNT_W{1'b0}};
      go_q     <= 1'b0;
      wop_q    <= 8'h00;
      wpg_q    <= 5'h00;
      wlk_q    <= 1'b0;
      miso     <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      s1_q     <= {wp_n, hold_n, mosi, cs_n, sclk};
      s2_q     <= s1_q;
      sclk_p_q <= sclk_s;
      cs_p_q   <= cs_s;
      ld_q     <= 1'b0;
      go_q     <= 1'b0;
      // Pause is only sampled while the clock is low
      if (cs_s)
        paused_q <= 1'b0;
      else if (!sclk_s)
        paused_q <= ~hold_s;
      if (ld_q) begin
        rd_q   <= rd_next;
        addr_q <= addr_q + 10'h001;
      end
      // Write cycle timer
      if (busy_q) begin
        if (cnt_q == {CNT_W{1'b0}}) begin
          busy_q <= 1'b0;
          go_q   <= 1'b1;
          wel_q  <= 1'b0;
          if (wop_q == `SEP_OP_STATUS_WRITE) begin
            status_write_disable_q <= srn_q[`SEP_SR_DISABLE_BIT];
            bp_q   <= {srn_q[`SEP_SR_BP_HI_BIT], srn_q[`SEP_SR_BP_LO_BIT]};
          end
          if (wlk_q && wop_q == `SEP_OP_IDPAGE_WRITE && bp_q != 2'b11)
            idlock_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      if (cs_fall) begin
        sel_q  <= 1'b1;
        st_q   <= ST_CMD;
        bit_q  <= 3'h0;
        // A status read during a write cycle must not wipe the page mask
        if (!busy_q)
          mask_q <= 32'h0;
        got_q  <= 1'b0;
        ab_q   <= 1'b0;
        lk_q   <= busy_q & lk_q;
        drv_q  <= 1'b0;
      end else if (cs_rise) begin
        sel_q <= 1'b0;
        st_q  <= ST_IDLE;
        drv_q <= 1'b0;
        // Paused or off-boundary deselect drops the command
        if (sel_q && !paused_q && bound) begin
          if (st_q == ST_DONE) begin
            if (op_q == `SEP_OP_ENABLE_WRITES && !busy_q)
              wel_q <= 1'b1;
            if (op_q == `SEP_OP_DISABLE_WRITES)
              wel_q <= 1'b0;
          end
          if (st_q == ST_DATA && got_q && wel_q && !busy_q) begin
            if (!(op_q == `SEP_OP_STATUS_WRITE && sr_locked)) begin
              busy_q <= 1'b1;
              cnt_q  <= TW_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
              // The cycle keeps its own copy of opcode, page and lock select
              wop_q  <= op_q;
              wpg_q  <= addr_q[9:5];
              wlk_q  <= lk_q;
            end
          end
        end
      end else if (rx) begin
        bit_q <= bit_q + 3'd1;
        sh_q  <= rx_byte;
        if (byte_done) begin
          case (st_q)
            ST_CMD: begin
              op_q <= rx_byte;
              lk_q <= 1'b0;
              if (!cmd_ok)
                st_q <= ST_WAIT;
              else begin
                case (rx_byte)
                  `SEP_OP_ENABLE_WRITES,
                  `SEP_OP_DISABLE_WRITES: st_q <= ST_DONE;
                  `SEP_OP_STATUS_READ: begin
                    st_q <= ST_READ;
                    ld_q <= 1'b1;
                  end
                  `SEP_OP_STATUS_WRITE: st_q <= ST_DATA;
                  `SEP_OP_ARRAY_READ,
                  `SEP_OP_ARRAY_WRITE,
                  `SEP_OP_IDPAGE_READ,
                  `SEP_OP_IDPAGE_WRITE: st_q <= ST_ADDR;
                  default: st_q <= ST_WAIT;
                endcase
              end
            end
            ST_ADDR: begin
              ahi_q <= rx_byte;
              ab_q  <= 1'b1;
              if (ab_q) begin
                addr_q <= afull[9:0];
                col_q  <= afull[4:0];
                lk_q   <= afull[`SEP_LOCK_SEL_BIT] & op_q[7];
                if (is_page_wr(op_q))
                  st_q <= ST_DATA;
                else begin
                  st_q <= ST_READ;
                  ld_q <= 1'b1;
                end
              end
            end
            ST_DATA: begin
              got_q <= 1'b1;
              if (op_q == `SEP_OP_STATUS_WRITE)
                srn_q <= rx_byte;
              else begin
                mask_q[col_q] <= 1'b1;
                col_q         <= col_q + 5'd1;
              end
            end
            ST_READ: ld_q <= 1'b1;
            ST_DONE: st_q <= ST_WAIT;
            default: st_q <= ST_WAIT;
          endcase
        end
      end else if (tx && st_q == ST_READ) begin
        miso  <= rd_q[3'd7 - bit_q];
        drv_q <= 1'b1;
      end
      // Driver follows select and pause every cycle
      miso_oe <= drv_q & sel_q & ~cs_s & ~paused_q & (st_q == ST_READ);
    end
  end

  // ----------------------------------------------------------------
  // Storage; array contents are not reset, like the real cells
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (byte_done && st_q == ST_DATA)
      pbuf[col_q] <= rx_byte;
    if (go_q) begin
      for (i = 0; i < 32; i = i + 1) begin
        if (mask_q[i]) begin
          if (wop_q == `SEP_OP_ARRAY_WRITE &&
              !prot({wpg_q, i[4:0]}, bp_q))
            mem[{wpg_q, i[4:0]}] <= pbuf[i];
          if (wop_q == `SEP_OP_IDPAGE_WRITE && !wlk_q && !idlock_q && bp_q != 2'b11)
            idp[i] <= pbuf[i];
        end
      end
    end
  end

endmodule // sep_eeprom
`default_nettype wire

// [verif/sep_assertions.sv]
// Pin-level checker for the serial EEPROM front end
`default_nettype none
module sep_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q;
  logic [3:0] fall_q;
  // ----
  // Cycles since pin clock fell
  // ----
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      fall_q <= 4'hF;
    end else begin
      sclk_q <= sclk;
      if (sclk_q && !sclk) fall_q <= 4'h0;
      else if (fall_q != 4'hF) fall_q <= fall_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  sequence s_desel; $rose(cs_n) ##1 cs_n [*3]; endsequence
  sequence s_pause; (!hold_n && !sclk) [*6]; endsequence
  property p_cs_off; s_desel |-> !miso_oe; endproperty
  a_cs_off: assert property (p_cs_off) else $error("output on after deselect");
  property p_oe_sel; $rose(miso_oe) |-> !cs_n && hold_n; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output on while unselected");
  property p_pause; s_pause |-> !miso_oe; endproperty
  a_pause: assert property (p_pause) else $error("output on during pause");
  property p_shift; $changed(miso) && miso_oe && $past(miso_oe) |-> fall_q <= 4'h6; endproperty
  a_shift: assert property (p_shift) else $error("data moved off a falling edge");
  property p_hi; sclk [*5] |-> $stable(miso); endproperty
  a_hi: assert property (p_hi) else $error("data moved with clock high");
  property p_start; $rose(miso_oe) && $past(hold_n, 8) |-> fall_q <= 4'h6; endproperty
  a_start: assert property (p_start) else $error("output began off a falling edge");
  property p_boot; $fell(rst) |-> !miso_oe [*8]; endproperty
  a_boot: assert property (p_boot) else $error("output on after reset");
  property p_keep; miso_oe && !cs_n && hold_n |=> miso_oe; endproperty
  a_keep: assert property (p_keep) else $error("read output dropped");
endmodule // sep_assertions

bind sep_eeprom sep_assertions u_chk (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .hold_n(hold_n), .miso(miso), .miso_oe(miso_oe));
`default_nettype wire

// [verif/sep_master.sv]
// Bus master model for the serial pins, clock modes 0 and 3
`default_nettype none
module sep_master (
  input  wire logic clk,
  input  wire logic miso,
  input  wire logic miso_oe,
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic mosi,
  output var  logic hold_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic oe_seen;
  logic cpol;
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    hold_n = 1'b1;
    oe_seen = 1'b0;
  end
  always @(posedge clk) if (miso_oe) oe_seen <= 1'b1;
  // ----
  // Bus cycles
  // ----
  task automatic sel();
    @(negedge clk) cs_n = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  // Released data line flips so a stale bit is never read as valid
  task automatic desel();
    @(negedge clk) cs_n = 1'b1;
    mosi = ~mosi;
    repeat (4) @(negedge clk);
  endtask
  task automatic bits(input logic [7:0] o, input int n, output logic [7:0] i);
    i = 8'h00;
    for (int k = 0; k < n; k++) begin
      @(negedge clk) sclk = 1'b0;
      mosi = o[7-k];
      repeat (5) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      i = {i[6:0], miso};
    end
    @(negedge clk) sclk = cpol;
  endtask
  // Idle level changes only while deselected
  task automatic mode(input logic p);
    @(negedge clk) cpol = p;
    sclk = p;
    repeat (4) @(negedge clk);
  endtask
  task automatic hold(input logic v);
    repeat (6) @(negedge clk);
    hold_n = v;
    repeat (6) @(negedge clk);
  endtask
  // Waits for the pending output bit to land before pausing
  task automatic pause(input int n, output logic oe);
    repeat (6) @(negedge clk);
    hold_n = 1'b0;
    repeat (n) @(negedge clk);
    oe = miso_oe;
    hold_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
endmodule // sep_master
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the serial EEPROM front end
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TW = 220; // Two status reads span one write cycle
  logic       clk, rst, wp_n, o;
  logic [7:0] r, q;
  wire        sclk, cs_n, mosi, hold_n, miso, miso_oe;
  int         error_cnt = 0, n_compared = 0, cyc = 0;
  sep_eeprom #(.TW_CYCLES(TW), .CNT_W(20)) DUT (.clk(clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe));
  sep_master m (.clk(clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .hold_n(hold_n));
  // ----
  // Command tasks
  // ----
  task automatic cmd(input logic [7:0] op);
    m.sel();
    m.bits(op, 8, r);
    m.desel();
  endtask
  task automatic status_read_cmd(input logic [7:0] want);
    m.sel();
    m.bits(8'h05, 8, r);
    m.bits(8'h00, 8, r);
    `CHK(r, want)
    m.desel();
  endtask
  task automatic status_write_cmd(input logic [7:0] v, input int n);
    m.sel();
    m.bits(8'h01, 8, r);
    m.bits(v, n, r);
    m.desel();
  endtask
  task automatic wrb(input logic [9:0] a, input logic [7:0] d);
    m.sel();
    m.bits(8'h02, 8, r);
    m.bits({6'h00, a[9:8]}, 8, r);
    m.bits(a[7:0], 8, r);
    m.bits(d, 8, r);
    m.desel();
  endtask
  task automatic rdb(input logic [9:0] a, input logic [7:0] want);
    m.sel();
    m.bits(8'h03, 8, r);
    m.bits({6'h00, a[9:8]}, 8, r);
    m.bits(a[7:0], 8, r);
    m.bits(8'h00, 8, r);
    `CHK(r, want)
    m.desel();
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    m.bits(8'h05, 8, r);
    m.bits(8'h00, 8, r);
    `CHK(m.oe_seen, 1'b0)
    m.desel();
    status_read_cmd(8'h00);
    cmd(8'h06);
    status_read_cmd(8'h02);
    cmd(8'h04);
    status_read_cmd(8'h00);
    status_write_cmd(8'h0C, 8);
    status_read_cmd(8'h00);
    cmd(8'h06);
    status_write_cmd(8'h8C, 7);
    status_read_cmd(8'h02);
    status_write_cmd(8'h8C, 8);
    status_read_cmd(8'h03);
    status_read_cmd(8'h8C);
    m.sel();
    m.bits(8'h05, 8, r);
    m.bits(8'h00, 4, r);
    m.pause(10, o);
    `CHK(o, 1'b0)
    m.bits(8'h00, 4, q);
    `CHK({r[3:0], q[3:0]}, 8'h8C)
    m.desel();
    @(negedge clk) wp_n = 1'b0;
    cmd(8'h06);
    status_write_cmd(8'h00, 8);
    status_read_cmd(8'h8E);
    @(negedge clk) wp_n = 1'b1;
    status_write_cmd(8'h00, 8);
    status_read_cmd(8'h8F);
    status_read_cmd(8'h00);
    cmd(8'h06);
    m.sel();
    m.bits(8'h01, 8, r);
    m.bits(8'h0C, 8, r);
    m.hold(1'b0);
    m.desel();
    m.hold(1'b1);
    status_read_cmd(8'h02);
    wrb(10'h3E1, 8'h5A);
    cmd(8'h04);
    status_read_cmd(8'h01);
    status_read_cmd(8'h00);
    rdb(10'h3E1, 8'h5A);
    cmd(8'h06);
    status_write_cmd(8'h04, 8);
    status_read_cmd(8'h03);
    status_read_cmd(8'h04);
    cmd(8'h06);
    wrb(10'h3E1, 8'hA5);
    status_read_cmd(8'h07);
    status_read_cmd(8'h04);
    rdb(10'h3E1, 8'h5A);
    m.mode(1'b1);
    status_read_cmd(8'h04);
    rdb(10'h3E1, 8'h5A);
    m.mode(1'b0);
    m.sel();
    m.bits(8'hFF, 8, r);
    m.oe_seen = 1'b0;
    m.bits(8'h00, 8, r);
    `CHK(m.oe_seen, 1'b0)
    m.desel();
    close_out();
  end
endmodule // testbench
`default_nettype wire
